//--- hw/pio_pkg.sv
// Package for the parallel handshake port: offsets, commands, config codes, carriers
package pio_pkg;
    // Local offsets within the eight-address block
    localparam logic [2:0] PIO_OFF_DATA0 = 3'h0;
    localparam logic [2:0] PIO_OFF_DATA1 = 3'h1;
    localparam logic [2:0] PIO_OFF_CTRL0 = 3'h6;
    localparam logic [2:0] PIO_OFF_CTRL1 = 3'h7;
    localparam logic [2:0] PIO_OFF_CFG = 3'h2;
    localparam logic [2:0] PIO_OFF_IRQST = 3'h3;
    localparam logic [2:0] PIO_OFF_IRQCLR = 3'h4;
    localparam logic [2:0] PIO_OFF_IRQEN = 3'h5;
    // Command bytes written to the control address
    localparam logic [7:0] PIO_CMD_CLR_OUT = 8'h20;
    localparam logic [7:0] PIO_CMD_CLR_IN = 8'h30;
    localparam logic [7:0] PIO_CMD_SET_OUT = 8'h60;
    // Status byte bit positions
    localparam int PIO_ST_OUTFLAG = 0;
    localparam int PIO_ST_INFLAG = 1;
    localparam int PIO_ST_ACK = 4;
    // Source codes for the configuration matrix
    localparam logic [2:0] PIO_SRC_LOW = 3'h0;
    localparam logic [2:0] PIO_SRC_ACK = 3'h1;
    localparam logic [2:0] PIO_SRC_ACK_INV = 3'h2;
    localparam logic [2:0] PIO_SRC_STB = 3'h3;
    localparam logic [2:0] PIO_SRC_STB_INV = 3'h4;
    localparam logic [2:0] PIO_SRC_HIGH = 3'h5;
    localparam logic [2:0] PIO_SRC_WPULSE = 3'h6;
    localparam logic [2:0] PIO_SRC_FREE = 3'h7;
    // Configuration register fields: five 3-bit selectors
    localparam int PIO_CFG_INCLK = 0;
    localparam int PIO_CFG_OUTCLK = 3;
    localparam int PIO_CFG_OE = 6;
    localparam int PIO_CFG_SPOUT = 9;
    localparam int PIO_CFG_SPIN = 12;
    localparam logic [14:0] PIO_CFG_RESET = {PIO_SRC_FREE, PIO_SRC_WPULSE, PIO_SRC_LOW,
                                             PIO_SRC_ACK, PIO_SRC_STB};
    // Free header lines idle high, so an active-low spare fed by one is driven active (low)
    localparam logic PIO_FREE_LEVEL = 1'b1;
    localparam logic PIO_FLAG_RESET = 1'b0;

    // Register bus request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pio_bus_t;

    // Pins of the output connector
    typedef struct packed {
        logic [7:0] data;
        logic dataOe;
        logic flagN;
        logic spareN;
    } pio_outpins_t;

    // Pins of the input connector
    typedef struct packed {
        logic flagN;
        logic spareN;
    } pio_inpins_t;
endpackage : pio_pkg

//--- hw/pio_port.sv
// Parallel input/output port with handshake flags and configuration matrix
`timescale 1ns/10ps
// Behaviour
// [RQ1] Input flag is set by an edge of a selectable source, normally strobe
// [RQ2] True and inverted input strobe are both selectable as input flag clock
// [RQ3] Output flag is set by an edge of a selectable source, normally acknowledge
// [RQ4] True and inverted acknowledge are both selectable as output flag clock
// [RQ5] Printer drives active-low acknowledge when ready or done with a byte
// [RQ6] Write pulse is high while host writes data to the output port
// [RQ7] Output latch drives data lines only while its selected enable is active
// [RQ8] Constant low and high are sources for every configurable control input
// [RQ9] Each connector has an active-low spare output fed by a selected source
// [RQ10] Reset config: enable low, true ack, write pulse spare, free spare, true strobe
// [RQ11] Input and output flags appear active low on their connectors
// [RQ12] Offsets 0 and 1: write loads output latch, read returns input byte
// [RQ13] Control commands 20h clear output, 30h clear input, 60h set output flag
// [RQ14] Output flag stays set after its edge until a host clear command
// [RQ15] Host reads both flags in the status byte at the control address
module pio_port (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus, with the output connector pins
    input wire pio_pkg::pio_bus_t bus,
    output pio_pkg::pio_outpins_t outPins,
    output logic [7:0] rdata,
    // Input connector
    input wire logic [7:0] inData,
    input wire logic inStrobe,
    output pio_pkg::pio_inpins_t inPins,
    // Output connector acknowledge, active low
    input wire logic ackN,
    // Interrupt
    output logic irq
);
    import pio_pkg::*;

    // Flag clocks are sampled on clk, not used as clocks: the matrix can hand a flag
    // the host write pulse or a constant, neither a clean clock, and one domain
    // keeps every flag, status bit and pin in step

    // Source selection shared by all matrix inputs
    function automatic logic pickSrc(input logic [2:0] sel, input logic ack,
                                     input logic stb, input logic wp);
        unique case (sel)
            PIO_SRC_LOW: pickSrc = 1'b0; // [RQ8]
            PIO_SRC_HIGH: pickSrc = 1'b1; // [RQ8]
            PIO_SRC_ACK: pickSrc = ack; // [RQ4]
            PIO_SRC_ACK_INV: pickSrc = ~ack; // [RQ4]
            PIO_SRC_STB: pickSrc = stb; // [RQ2]
            PIO_SRC_STB_INV: pickSrc = ~stb; // [RQ2]
            PIO_SRC_WPULSE: pickSrc = wp;
            PIO_SRC_FREE: pickSrc = PIO_FREE_LEVEL;
        endcase
    endfunction : pickSrc

    // Offset decode for the strobe logic; the read multiplexer decodes offsets in its own case
    // Each returns one bit so the callers read as plain conditions
    function automatic logic isDataOff(input logic [2:0] a);
        isDataOff = (a == PIO_OFF_DATA0) || (a == PIO_OFF_DATA1);
    endfunction : isDataOff

    // Offsets 6 and 7 both reach the control and status byte
    function automatic logic isCtrlOff(input logic [2:0] a);
        isCtrlOff = (a == PIO_OFF_CTRL0) || (a == PIO_OFF_CTRL1);
    endfunction : isCtrlOff

    // Synchronised pins
    logic [1:0] stbSync_reg;
    logic [1:0] ackSync_reg;
    logic [7:0] inSync1_reg;
    logic [7:0] inSync2_reg;
    // Host-visible state
    logic [14:0] cfg_reg;
    logic [7:0] latch_reg;
    logic inFlag_reg;
    logic outFlag_reg;
    logic inClkPrev_reg;
    logic outClkPrev_reg;
    logic [1:0] irqSt_reg;
    logic [1:0] irqEn_reg;
    // Combinational decode
    logic [7:0] rdata_next;
    logic ackLine;
    logic wPulse;
    logic inClk;
    logic outClk;
    logic inEdge;
    logic outEdge;
    logic ctrlWr;
    logic ctrlAddr;
    // Decoded strobes and commands
    logic cfgWr;
    logic [14:0] cfgWord;
    logic irqClrWr;
    logic irqEnWr;
    logic cmdClrOut;
    logic cmdClrIn;
    logic cmdSetOut;
    // Matrix picks for the latch enable and spares
    logic oeSrc;
    logic spOutSrc;
    logic spInSrc;
    // Connector pin flip-flops
    logic [7:0] outData_reg;
    logic dataOe_reg;
    logic outFlagN_reg;
    logic inFlagN_reg;
    logic outSpareN_reg;
    logic inSpareN_reg;

    // Pins are asynchronous to clk, two stages before any use
    // A pin may change anywhere in the cycle; only the second stage is read
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stbSync_reg <= 2'h0;
            ackSync_reg <= 2'h3;
            inSync1_reg <= 8'h00;
            inSync2_reg <= 8'h00;
        end
        else
        begin
            stbSync_reg <= {stbSync_reg[0], inStrobe};
            ackSync_reg <= {ackSync_reg[0], ackN};
            inSync1_reg <= inData;
            inSync2_reg <= inSync1_reg;
        end
    end

    // Acknowledge as a true-high ready level; the printer drives it low when ready
    assign ackLine = ~ackSync_reg[1]; // [RQ5]
    // Host strobe decode
    assign ctrlAddr = isCtrlOff(bus.addr);
    assign ctrlWr = bus.wr && ctrlAddr;
    assign wPulse = bus.wr && isDataOff(bus.addr); // [RQ6]
    // Register strobes, one per writable offset
    assign cfgWr = bus.wr && (bus.addr == PIO_OFF_CFG);
    assign irqClrWr = bus.wr && (bus.addr == PIO_OFF_IRQCLR);
    assign irqEnWr = bus.wr && (bus.addr == PIO_OFF_IRQEN);
    // Flag commands; any other control byte falls through and is ignored
    assign cmdClrOut = ctrlWr && (bus.wdata == PIO_CMD_CLR_OUT); // [RQ13]
    assign cmdClrIn = ctrlWr && (bus.wdata == PIO_CMD_CLR_IN); // [RQ13]
    assign cmdSetOut = ctrlWr && (bus.wdata == PIO_CMD_SET_OUT); // [RQ13]
    // Flag clocks through the matrix, then a rising-edge detect on clk
    assign inClk = pickSrc(cfg_reg[PIO_CFG_INCLK +: 3], ackLine, stbSync_reg[1], wPulse); // [RQ1]
    assign outClk = pickSrc(cfg_reg[PIO_CFG_OUTCLK +: 3], ackLine, stbSync_reg[1], wPulse); // [RQ3]
    assign inEdge = inClk && !inClkPrev_reg;
    assign outEdge = outClk && !outClkPrev_reg;
    // One byte feeds all fifteen selector bits: the byte, then its seven low bits again
    assign cfgWord = {bus.wdata[6:0], bus.wdata[7:0]};

    // Configuration matrix register; reset gives the shipped wiring.
    // An all-zero write is dropped, since it would tie every selector low at once
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cfg_reg <= PIO_CFG_RESET; // [RQ10]
        else if (cfgWr && (cfgWord != 15'h0000))
            cfg_reg <= cfgWord;
    end

    // Output latch; loaded by a data write
    // A later write simply overwrites, so the printer must take each byte in time
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            latch_reg <= 8'h00;
        else if (wPulse)
            latch_reg <= bus.wdata; // [RQ12]
    end

    // Previous flag clock levels for rising-edge detection; reset high so a
    // source already high at release does not count as an edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            inClkPrev_reg <= 1'b1;
            outClkPrev_reg <= 1'b1;
        end
        else
        begin
            inClkPrev_reg <= inClk;
            outClkPrev_reg <= outClk;
        end
    end

    // Input flag: edge sets, command clears; set wins a tie so no byte is lost
    // Software reads the byte before clearing, so a late clear never hides a key
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            inFlag_reg <= PIO_FLAG_RESET;
        else if (inEdge)
            inFlag_reg <= 1'b1; // [RQ1]
        else if (cmdClrIn)
            inFlag_reg <= 1'b0; // [RQ13]
    end

    // Output flag: sticky after its edge until the host clears it
    // The set command shares the set branch, so it also beats a clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            outFlag_reg <= PIO_FLAG_RESET;
        else if (outEdge || cmdSetOut)
            outFlag_reg <= 1'b1; // [RQ14] [RQ13]
        else if (cmdClrOut)
            outFlag_reg <= 1'b0; // [RQ13]
    end

    // Interrupt status: sticky on flag-setting edges, set beats clear
    // A clear write masks only the bits it names
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irqSt_reg <= 2'h0;
        else
            irqSt_reg <= {outEdge, inEdge} |
                         (irqSt_reg & ~(irqClrWr ? bus.wdata[1:0] : 2'h0));
    end

    // Interrupt enable register, written whole
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irqEn_reg <= 2'h0;
        else if (irqEnWr)
            irqEn_reg <= bus.wdata[1:0];
    end

    // Level interrupt; lags the status by one cycle and drops with it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(irqSt_reg & irqEn_reg);
    end

    // Read multiplexer; result stands in the cycle after the strobe
    // Zero unless a read was taken, so idle cycles return zero
    always_comb
    begin
        rdata_next = 8'h00;
        if (bus.rd)
        begin
            unique case (bus.addr)
                PIO_OFF_DATA0, PIO_OFF_DATA1: rdata_next = inSync2_reg; // [RQ12]
                PIO_OFF_CTRL0, PIO_OFF_CTRL1:
                begin
                    rdata_next[PIO_ST_OUTFLAG] = outFlag_reg; // [RQ15]
                    rdata_next[PIO_ST_INFLAG] = inFlag_reg; // [RQ15]
                    rdata_next[PIO_ST_ACK] = ackLine;
                end
                PIO_OFF_CFG: rdata_next = cfg_reg[7:0];
                PIO_OFF_IRQST: rdata_next = {6'h00, irqSt_reg};
                PIO_OFF_IRQEN: rdata_next = {6'h00, irqEn_reg};
                PIO_OFF_IRQCLR: rdata_next = 8'h00;
            endcase
        end
    end

    // Every pin below is a flip-flop so nothing combinational reaches a connector
    // Matrix picks for the latch enable and the two spare lines
    assign oeSrc = pickSrc(cfg_reg[PIO_CFG_OE +: 3], ackLine, stbSync_reg[1], wPulse); // [RQ7]
    assign spOutSrc = pickSrc(cfg_reg[PIO_CFG_SPOUT +: 3], ackLine, stbSync_reg[1], wPulse);
    assign spInSrc = pickSrc(cfg_reg[PIO_CFG_SPIN +: 3], ackLine, stbSync_reg[1], wPulse);

    // Read data register; stands for one cycle only
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata <= 8'h00;
        else
            rdata <= rdata_next;
    end

    // Data pins follow the latch one cycle later
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            outData_reg <= 8'h00;
        else
            outData_reg <= latch_reg; // [RQ12]
    end

    // Enable input is active low: a low source keeps the latch driving
    // A selected pulse source makes the data lines blink, which is the user's choice
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            dataOe_reg <= 1'b1;
        else
            dataOe_reg <= !oeSrc; // [RQ7]
    end

    // Output flag on its connector, active low
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            outFlagN_reg <= 1'b1;
        else
            outFlagN_reg <= !outFlag_reg; // [RQ11]
    end

    // Input flag on its connector, active low
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            inFlagN_reg <= 1'b1;
        else
            inFlagN_reg <= !inFlag_reg; // [RQ11]
    end

    // Output spare inverts its source so a high source asserts it
    // With the write pulse selected it gives the printer a one-cycle strobe
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            outSpareN_reg <= 1'b1;
        else
            outSpareN_reg <= !spOutSrc; // [RQ9]
    end

    // Input spare, same inversion as the output spare
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            inSpareN_reg <= 1'b1;
        else
            inSpareN_reg <= !spInSrc; // [RQ9]
    end

    // Connector carriers gathered straight from the flip-flops above
    // Plain wiring only, so each pin keeps its own flip-flop timing
    assign outPins = '{data: outData_reg, dataOe: dataOe_reg, flagN: outFlagN_reg,
                       spareN: outSpareN_reg};
    assign inPins = '{flagN: inFlagN_reg, spareN: inSpareN_reg};
endmodule : pio_port

//--- bench/pio_assertions.sv
// Pin-level checks for the parallel handshake port
`timescale 1ns/10ps
module pio_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched ports
    input wire pio_pkg::pio_bus_t bus,
    input wire pio_pkg::pio_outpins_t outPins,
    input wire logic [7:0] rdata,
    input wire pio_pkg::pio_inpins_t inPins
);
    import pio_pkg::*;
    logic ctl;
    logic clrOut;
    logic clrIn;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // Control address decode; offsets 6 and 7 mirror each other
    assign ctl = bus.addr[2:1] == 2'h3;
    assign clrOut = bus.wr && ctl && bus.wdata == PIO_CMD_CLR_OUT;
    assign clrIn = bus.wr && ctl && bus.wdata == PIO_CMD_CLR_IN;
    sequence ctrlWr(cmd);
        bus.wr && ctl && bus.wdata == cmd;
    endsequence
    sequence statRd;
        bus.rd && ctl;
    endsequence
    AST_RD_IDLE: assert property (!bus.rd |=> rdata == 8'h00)
        else $error("read data not zero");
    AST_LATCH: assert property (bus.wr && bus.addr[2:1] == 2'h0 |-> ##2
        outPins.data == $past(bus.wdata, 2)) else $error("latch wrong");
    AST_CLR_OUT: assert property (ctrlWr(PIO_CMD_CLR_OUT) |-> ##[1:3] outPins.flagN)
        else $error("output flag not cleared");
    AST_SET_OUT: assert property (ctrlWr(PIO_CMD_SET_OUT) |-> ##[1:3] !outPins.flagN)
        else $error("output flag not set");
    // A flag drops only through its own clear command, since set wins
    AST_OUT_HOLD: assert property ($rose(outPins.flagN) |-> $past(clrOut, 2))
        else $error("output flag lost");
    AST_IN_HOLD: assert property ($rose(inPins.flagN) |-> $past(clrIn, 2))
        else $error("input flag lost");
    AST_ST_OUT: assert property (statRd |=> rdata[PIO_ST_OUTFLAG] == !outPins.flagN)
        else $error("status output flag");
    AST_ST_IN: assert property (statRd |=> rdata[PIO_ST_INFLAG] == !inPins.flagN)
        else $error("status input flag");
endmodule : pio_assertions

//--- bench/pio_periph_model.sv
// Keyboard and printer standing on the far side of the port
`timescale 1ns/10ps
module pio_periph_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Printer strobe taken from the output spare
    input wire logic spareN,
    // Peripheral lines
    output logic [7:0] inData,
    output logic inStrobe,
    output logic ackN
);
    int lag = 8;
    // Printer is busy at power up and reports ready later
    initial
    begin
        inData = 8'h00;
        inStrobe = 1'b0;
        ackN = 1'b1;
        @(negedge rst);
        repeat (lag) @(posedge clk);
        ackN <= 1'b0;
    end
    // A strobe makes the printer busy, then done; strobes while busy are lost
    always @(posedge spareN)
    begin
        if (rst === 1'b0)
        begin
            @(posedge clk);
            ackN <= 1'b1;
            repeat (lag) @(posedge clk);
            ackN <= 1'b0;
        end
    end
    // Keyboard holds its byte until the next key
    task automatic key(input logic [7:0] d);
        @(posedge clk);
        inData <= d;
        inStrobe <= 1'b1;
    endtask : key
    task automatic keyUp();
        @(posedge clk);
        inStrobe <= 1'b0;
    endtask : keyUp
endmodule : pio_periph_model

//--- bench/tb_pio_port.sv
// Self-checking bench for the parallel handshake port
`timescale 1ns/10ps
module tb_pio_port;
    import pio_pkg::*;
    localparam logic [2:0] CT = PIO_OFF_CTRL0;
    logic clk = 1'b0;
    logic rst = 1'b1;
    pio_bus_t bus = '0;
    pio_outpins_t outPins;
    pio_inpins_t inPins;
    logic [7:0] rdata;
    logic [7:0] inData;
    logic inStrobe;
    logic ackN;
    logic irq;
    int fail_count = 0;
    int tests_run = 0;
    // 40 MHz clock
    always #12.5 clk = ~clk;
    pio_port i_pio_port (.clk(clk), .rst(rst), .bus(bus), .outPins(outPins),
        .rdata(rdata), .inData(inData), .inStrobe(inStrobe), .inPins(inPins),
        .ackN(ackN), .irq(irq));
    pio_periph_model i_pio_periph_model (.clk(clk), .rst(rst),
        .spareN(outPins.spareN), .inData(inData), .inStrobe(inStrobe), .ackN(ackN));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 chk(rdata, exp);
    endtask : rd
    task automatic complete_run();
        $display("compares %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run
    // Watchdog well beyond the 160 or so cycles the tests take
    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        complete_run();
    end
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(CT, 8'h00);
        rd(PIO_OFF_CFG, PIO_CFG_RESET[7:0]);
        chk(8'(outPins.dataOe), 8'h01);
        repeat (16) @(posedge clk);
        rd(CT, 8'h11);
        chk(8'(outPins.flagN), 8'h00);
        rd(PIO_OFF_IRQST, 8'h02);
        chk(8'(irq), 8'h00);
        wr(PIO_OFF_IRQEN, 8'h02);
        repeat (3) @(posedge clk);
        chk(8'(irq), 8'h01);
        wr(PIO_OFF_IRQCLR, 8'h02);
        repeat (3) @(posedge clk);
        chk(8'(irq), 8'h00);
        // Print: write pulse strobes the printer, ack sets the flag again
        wr(PIO_OFF_DATA0, 8'hA5);
        wr(PIO_OFF_DATA1, 8'h3C);
        wr(PIO_OFF_CTRL1, PIO_CMD_CLR_OUT);
        repeat (3) @(posedge clk);
        rd(CT, 8'h00);
        chk(outPins.data, 8'h3C);
        repeat (20) @(posedge clk);
        rd(PIO_OFF_CTRL1, 8'h11);
        wr(CT, PIO_CMD_CLR_OUT);
        wr(CT, 8'h40);
        rd(CT, 8'h10);
        wr(CT, PIO_CMD_SET_OUT);
        rd(CT, 8'h11);
        // Keyboard on true strobe
        i_pio_periph_model.key(8'h5A);
        repeat (8) @(posedge clk);
        rd(CT, 8'h13);
        chk(8'(inPins.flagN), 8'h00);
        rd(PIO_OFF_DATA0, 8'h5A);
        rd(PIO_OFF_DATA1, 8'h5A);
        i_pio_periph_model.keyUp();
        wr(CT, PIO_CMD_CLR_IN);
        rd(CT, 8'h11);
        // Inverted strobe, constant high output clock, inverted ack to input spare
        wr(PIO_OFF_CFG, 8'h2C);
        rd(PIO_OFF_CFG, 8'h2C);
        wr(CT, PIO_CMD_CLR_IN);
        i_pio_periph_model.key(8'hC3);
        repeat (8) @(posedge clk);
        rd(CT, 8'h11);
        i_pio_periph_model.keyUp();
        repeat (8) @(posedge clk);
        rd(CT, 8'h13);
        chk(8'(inPins.spareN), 8'(!ackN));
        wr(CT, PIO_CMD_CLR_OUT);
        wr(PIO_OFF_DATA0, 8'h77);
        repeat (24) @(posedge clk);
        rd(CT, 8'h12);
        complete_run();
    end
endmodule : tb_pio_port
bind pio_port pio_assertions i_pio_assertions (.clk(clk), .rst(rst), .bus(bus),
    .outPins(outPins), .rdata(rdata), .inPins(inPins));
